// ==== design/fwec_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef FWEC_REGS_SVH
`define FWEC_REGS_SVH
`define FWEC_PSC_ADDR 8'h8F
`define FWEC_OSH_ADDR 8'hAF
`define FWEC_FSC_ADDR 8'hB6
`define FWEC_KEY_ADDR 8'hB7
`define FWEC_PSC_RST 8'h00
`define FWEC_OSH_RST 8'h0F
`define FWEC_FSC_RST 8'h03
`define FWEC_WE_BIT 0
`define FWEC_EE_BIT 1
`define FWEC_RT_BIT 4
`define FWEC_KEY1 8'hA5
`define FWEC_KEY2 8'hF1
`define FWEC_CLK_NS 20
`define FWEC_STEP_NS 5
`define FWEC_RSV_LO 16'h7E00
`define FWEC_RSV_HI 16'h7FFF
`define FWEC_PAGE_BITS 9
`define FWEC_WRITE_CYC 4
`define FWEC_ERASE_CYC 16
`endif

// ==== design/fwec_pkg.sv ====
// Types used only by the device end of the flash controller
package fwec_pkg;
	typedef enum logic [1:0] {
		FWEC_LOCKED,
		FWEC_KEY1_OK,
		FWEC_UNLOCKED,
		FWEC_DISABLED
	} fwec_lock_type;
	typedef enum logic [1:0] {
		FWEC_OP_IDLE,
		FWEC_OP_WRITE,
		FWEC_OP_ERASE
	} fwec_op_type;
endpackage

// ==== design/fwec_if.sv ====
// Interface between processor core and flash controller
`timescale 1ns/100ps
interface fwec_if;
	logic sfr_wr;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic mv_wr;
	logic mv_rd;
	logic [15:0] mv_addr;
	logic [7:0] mv_wdata;
	logic [7:0] mv_rdata;
	logic busy;
	logic fetch;
	modport dev (input sfr_wr, sfr_addr, sfr_wdata, mv_wr, mv_rd, mv_addr, mv_wdata, fetch,
		output sfr_rdata, mv_rdata, busy);
	modport cpu (output sfr_wr, sfr_addr, sfr_wdata, mv_wr, mv_rd, mv_addr, mv_wdata, fetch,
		input sfr_rdata, mv_rdata, busy);
endinterface

// ==== design/fwec_device.sv ====
// Flash write/erase controller and read strobe timing
`timescale 1ns/100ps
`include "fwec_regs.svh"
// Overview of operation
// - Write enable steers move writes to flash
// - Write enable clear: moves hit data RAM
// - Erase plus write enable erases page
// - Firmware erases before programming a byte
// - Control register upper six bits read zero
// - Keys A5 then F1 unlock flash
// - Permission withdrawn after each operation
// - Bad key or attempt locks until reset; a key write while a write or erase runs drops back to locked when it ends
// - Key register reads lock state
// - Read strobe one or two clocks
// - Software sets read time above 25MHz
// - Flash idles when strobe deasserted
// - One-shot limits strobe at slow clocks
// - Limit width five ns times code+1
// - Limit ignored above 12.5MHz, read-time zero
// - Software keeps one-shot at least 40ns
// - Software follows read timing update order
// - Scale reserved upper bits read zero
// - One-shot upper four bits read zero
// - Region 7E00-7FFF reserved
// - Reserved region access causes error reset
// - Modify with monitor off: error reset
module fwec_device #(
	parameter int CLK_NS = `FWEC_CLK_NS,
	parameter int WRITE_CYC = `FWEC_WRITE_CYC,
	parameter int ERASE_CYC = `FWEC_ERASE_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_reset,
	fwec_if.dev bus,
	input wire logic i_supply_mon_on,
	input wire logic i_supply_rst_en,
	output logic o_flash_strobe,
	output logic o_flash_prog,
	output logic o_flash_erase,
	output logic [15:0] o_flash_addr,
	output logic [7:0] o_flash_data,
	output logic o_ram_we,
	output logic [15:0] o_ram_addr,
	output logic [7:0] o_ram_data,
	output logic o_flash_error_reset
);
	localparam int SLOW_NS = 80;
	logic [1:0] psc_r;
	logic [3:0] osh_r;
	logic fsc_rt_r;
	logic [1:0] fsc_lo_r;
	fwec_pkg::fwec_lock_type lock_r;
	fwec_pkg::fwec_lock_type lock_nxt;
	fwec_pkg::fwec_op_type op_r;
	logic [15:0] cnt_r;
	logic [1:0] stb_cnt_r;
	logic [7:0] rdata_r;
	logic busy_r;

	wire key_wr = bus.sfr_wr && bus.sfr_addr == `FWEC_KEY_ADDR;
	wire we_on = psc_r[`FWEC_WE_BIT];
	wire ee_on = psc_r[`FWEC_EE_BIT];
	wire in_rsv = bus.mv_addr >= `FWEC_RSV_LO && bus.mv_addr <= `FWEC_RSV_HI;
	wire fl_wr = bus.mv_wr && we_on && !busy_r;
	wire ram_wr = bus.mv_wr && !we_on && !busy_r;
	wire mon_bad = !(i_supply_mon_on && i_supply_rst_en);
	wire err_rst = (fl_wr && (in_rsv || mon_bad)) || (bus.mv_rd && we_on && in_rsv);
	wire op_ok = fl_wr && !err_rst && lock_r == fwec_pkg::FWEC_UNLOCKED;
	wire op_bad = fl_wr && !err_rst && lock_r != fwec_pkg::FWEC_UNLOCKED;
	wire op_done = op_r != fwec_pkg::FWEC_OP_IDLE && cnt_r == 16'h0001;
	// Strobe limit: only a slow clock (period over 80ns) caps width, in either read-time mode
	wire [15:0] lim_ns = 16'((int'(osh_r) + 1) * `FWEC_STEP_NS);
	wire limit_on = CLK_NS > SLOW_NS;
	wire strobe_req = bus.fetch || bus.mv_rd;
	wire [1:0] stb_len = fsc_rt_r ? 2'h2 : 2'h1;
	wire [15:0] ns_each = 16'(CLK_NS);

	always_comb begin
		lock_nxt = lock_r;
		if (op_done) begin
			lock_nxt = fwec_pkg::FWEC_LOCKED;
		end
		if (op_bad) begin
			lock_nxt = fwec_pkg::FWEC_DISABLED;
		end
		if (key_wr) begin
			case (lock_r)
				fwec_pkg::FWEC_LOCKED: lock_nxt = bus.sfr_wdata == `FWEC_KEY1 ?
					fwec_pkg::FWEC_KEY1_OK : fwec_pkg::FWEC_DISABLED;
				fwec_pkg::FWEC_KEY1_OK: lock_nxt = bus.sfr_wdata == `FWEC_KEY2 ?
					fwec_pkg::FWEC_UNLOCKED : fwec_pkg::FWEC_DISABLED;
				fwec_pkg::FWEC_UNLOCKED: lock_nxt = fwec_pkg::FWEC_DISABLED;
				default: lock_nxt = fwec_pkg::FWEC_DISABLED;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			psc_r <= 2'h0;
			osh_r <= 4'hF;
			fsc_rt_r <= 1'b0;
			fsc_lo_r <= 2'h3;
			lock_r <= fwec_pkg::FWEC_LOCKED;
		end else begin
			lock_r <= lock_nxt;
			if (bus.sfr_wr && bus.sfr_addr == `FWEC_PSC_ADDR) begin
				psc_r <= bus.sfr_wdata[1:0];
			end
			if (bus.sfr_wr && bus.sfr_addr == `FWEC_OSH_ADDR) begin
				osh_r <= bus.sfr_wdata[3:0];
			end
			if (bus.sfr_wr && bus.sfr_addr == `FWEC_FSC_ADDR) begin
				fsc_rt_r <= bus.sfr_wdata[`FWEC_RT_BIT];
				fsc_lo_r <= bus.sfr_wdata[1:0];
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			op_r <= fwec_pkg::FWEC_OP_IDLE;
			cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			o_flash_prog <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_addr <= 16'h0000;
			o_flash_data <= 8'h00;
		end else if (op_ok) begin
			op_r <= ee_on ? fwec_pkg::FWEC_OP_ERASE : fwec_pkg::FWEC_OP_WRITE;
			cnt_r <= ee_on ? 16'(ERASE_CYC) : 16'(WRITE_CYC);
			busy_r <= 1'b1;
			o_flash_prog <= !ee_on;
			o_flash_erase <= ee_on;
			o_flash_addr <= ee_on ? {bus.mv_addr[15:`FWEC_PAGE_BITS], 9'h000} : bus.mv_addr;
			o_flash_data <= ee_on ? 8'hFF : bus.mv_wdata;
		end else if (op_done) begin
			op_r <= fwec_pkg::FWEC_OP_IDLE;
			cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			o_flash_prog <= 1'b0;
			o_flash_erase <= 1'b0;
		end else if (op_r != fwec_pkg::FWEC_OP_IDLE) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			stb_cnt_r <= 2'h0;
			o_flash_strobe <= 1'b0;
			o_ram_we <= 1'b0;
			o_ram_addr <= 16'h0000;
			o_ram_data <= 8'h00;
			o_flash_error_reset <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			o_ram_we <= ram_wr;
			o_ram_addr <= bus.mv_addr;
			o_ram_data <= bus.mv_wdata;
			o_flash_error_reset <= err_rst;
			if (strobe_req && stb_cnt_r == 2'h0) begin
				stb_cnt_r <= stb_len;
				// First strobe clock is suppressed only for a zero limit; later clocks drop when limit is under one clock
				o_flash_strobe <= !(limit_on && lim_ns == 16'h0000);
			end else if (stb_cnt_r != 2'h0) begin
				stb_cnt_r <= stb_cnt_r - 2'h1;
				o_flash_strobe <= stb_cnt_r != 2'h1 && !(limit_on && lim_ns < ns_each);
			end else begin
				o_flash_strobe <= 1'b0;
			end
			case (bus.sfr_addr)
				`FWEC_PSC_ADDR: rdata_r <= {6'h00, psc_r};
				`FWEC_OSH_ADDR: rdata_r <= {4'h0, osh_r};
				`FWEC_FSC_ADDR: rdata_r <= {3'h0, fsc_rt_r, 2'h0, fsc_lo_r};
				`FWEC_KEY_ADDR: rdata_r <= {6'h00, lock_r};
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign bus.sfr_rdata = rdata_r;
	assign bus.mv_rdata = 8'h00;
	assign bus.busy = busy_r;
endmodule

// ==== design/fwec_core.sv ====
// Processor-side end issuing register and move requests
`timescale 1ns/100ps
`include "fwec_regs.svh"
module fwec_core (
	input wire logic i_core_clk,
	input wire logic i_reset,
	fwec_if.cpu bus,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_mv_wr,
	input wire logic i_mv_rd,
	input wire logic i_fetch,
	input wire logic [15:0] i_mv_addr,
	input wire logic [7:0] i_mv_wdata,
	output logic [7:0] o_sfr_rdata,
	output logic o_stall
);
	logic sfr_wr_r;
	logic [7:0] sfr_addr_r;
	logic [7:0] sfr_wdata_r;
	logic mv_wr_r;
	logic mv_rd_r;
	logic fetch_r;
	logic [15:0] mv_addr_r;
	logic [7:0] mv_wdata_r;
	wire hold = bus.busy;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sfr_wr_r <= 1'b0;
			sfr_addr_r <= 8'h00;
			sfr_wdata_r <= 8'h00;
			mv_wr_r <= 1'b0;
			mv_rd_r <= 1'b0;
			fetch_r <= 1'b0;
			mv_addr_r <= 16'h0000;
			mv_wdata_r <= 8'h00;
			o_sfr_rdata <= 8'h00;
			o_stall <= 1'b0;
		end else begin
			o_stall <= hold;
			o_sfr_rdata <= bus.sfr_rdata;
			sfr_addr_r <= i_sfr_addr;
			sfr_wr_r <= i_sfr_wr && !hold;
			// Reserved scale bits are always written as zero
			sfr_wdata_r <= i_sfr_addr == `FWEC_FSC_ADDR ?
				(i_sfr_wdata & 8'h10) : i_sfr_wdata;
			mv_wr_r <= i_mv_wr && !hold;
			mv_rd_r <= i_mv_rd && !hold;
			fetch_r <= i_fetch && !hold;
			mv_addr_r <= i_mv_addr;
			mv_wdata_r <= i_mv_wdata;
		end
	end

	assign bus.sfr_wr = sfr_wr_r;
	assign bus.sfr_addr = sfr_addr_r;
	assign bus.sfr_wdata = sfr_wdata_r;
	assign bus.mv_wr = mv_wr_r;
	assign bus.mv_rd = mv_rd_r;
	assign bus.fetch = fetch_r;
	assign bus.mv_addr = mv_addr_r;
	assign bus.mv_wdata = mv_wdata_r;
endmodule

// ==== dv/fwec_sva.sv ====
// Assertions on the core-to-controller interface
`timescale 1ns/100ps
module fwec_sva (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic mv_wr,
	input wire logic busy
);
	logic [7:0] last_r;
	logic dis_r;
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			last_r <= 8'h00;
			dis_r <= 1'b0;
		end else begin
			last_r <= sfr_addr;
			dis_r <= dis_r | (last_r == 8'hB7 && sfr_rdata[1:0] == 2'b11);
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	a_ctl_upper_zero: assert property (last_r == 8'h8F |-> sfr_rdata[7:2] == 6'h00)
		else $error("control upper bits set");
	a_osh_upper_zero: assert property (last_r == 8'hAF |-> sfr_rdata[7:4] == 4'h0)
		else $error("one-shot upper bits set");
	a_scl_upper_zero: assert property (last_r == 8'hB6 |-> sfr_rdata[7:5] == 3'h0)
		else $error("scale upper bits set");
	a_bad_key_locks: assert property (sfr_wr && sfr_addr == 8'hB7 && sfr_wdata != 8'hA5
		&& sfr_wdata != 8'hF1 ##1 sfr_addr == 8'hB7 |=> sfr_rdata[1:0] == 2'b11)
		else $error("bad key did not lock");
	a_lock_stays: assert property (dis_r && last_r == 8'hB7 |-> sfr_rdata[1:0] == 2'b11)
		else $error("lockout lifted");
	a_busy_cause: assert property ($rose(busy) |-> $past(mv_wr))
		else $error("busy without move write");
	a_busy_min: assert property ($rose(busy) |-> busy[*4])
		else $error("busy too short");
	a_busy_max: assert property ($rose(busy) |-> ##[4:16] !busy)
		else $error("busy too long");
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the flash write and erase controller
`timescale 1ns/100ps
module tb;
	logic clk = 0, rst = 1, sw = 0, mw = 0, mr = 0, fe = 0, mon = 1, ren = 1;
	logic [7:0] sa = 8'h00, sd = 8'h00, rd, fd, pd, ed, rdat, rdd;
	logic [15:0] ma = 16'h0000, fa, ea, pa, radr, ra;
	logic stall, stb, prg, ers, rwe, err;
	int fails = 0, checks = 0;
	int n[6], b[6];
	fwec_if bus_if();
	fwec_core fwec_core_i(.i_core_clk(clk), .i_reset(rst), .bus(bus_if.cpu), .i_sfr_wr(sw),
		.i_sfr_addr(sa), .i_sfr_wdata(sd), .i_mv_wr(mw), .i_mv_rd(mr), .i_fetch(fe),
		.i_mv_addr(ma), .i_mv_wdata(8'h3C), .o_sfr_rdata(rd), .o_stall(stall));
	fwec_device fwec_device_i(.i_core_clk(clk), .i_reset(rst), .bus(bus_if.dev),
		.i_supply_mon_on(mon), .i_supply_rst_en(ren), .o_flash_strobe(stb), .o_flash_prog(prg),
		.o_flash_erase(ers), .o_flash_addr(fa), .o_flash_data(fd), .o_ram_we(rwe),
		.o_ram_addr(radr), .o_ram_data(rdat), .o_flash_error_reset(err));
	fwec_sva fwec_sva_i(.i_core_clk(clk), .i_reset(rst), .sfr_wr(bus_if.sfr_wr),
		.sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata), .sfr_rdata(bus_if.sfr_rdata),
		.mv_wr(bus_if.mv_wr), .busy(bus_if.busy));
	initial begin
		forever #10 clk = ~clk;
	end
	// Outputs are counted and captured mid-cycle, where they are settled
	always @(negedge clk) begin
		n[0] += stb;
		n[1] += prg;
		n[2] += ers;
		n[3] += rwe;
		n[4] += err;
		n[5] += stall;
		if (ers) begin
			ea = fa;
			ed = fd;
		end
		if (prg) begin
			pa = fa;
			pd = fd;
		end
		if (rwe) begin
			ra = radr;
			rdd = rdat;
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic dlt(input int i, input int e);
		chk(16'(n[i] - b[i]), 16'(e));
	endtask
	task automatic rs();
		rst = 1;
		cyc(5);
		rst = 0;
		cyc(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sw = 1;
		sa = a;
		sd = d;
		cyc(1);
		sw = 0;
		cyc(2);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		sa = a;
		cyc(4);
		chk({8'h00, rd}, {8'h00, e});
	endtask
	task automatic mv(input logic w, input logic [15:0] a);
		b = n;
		ma = a;
		mw = w;
		mr = !w;
		cyc(1);
		mw = 0;
		mr = 0;
		cyc(2);
		for (int i = 0; i < 40 && stall !== 1'b0; i++) cyc(1);
		cyc(2);
	endtask
	task automatic unl(input logic [7:0] c);
		wr(8'hB7, 8'hA5);
		wr(8'hB7, 8'hF1);
		wr(8'h8F, c);
	endtask
	task automatic fch(input logic [7:0] s, input int e);
		wr(8'hB6, s);
		b = n;
		fe = 1;
		cyc(1);
		fe = 0;
		cyc(6);
		dlt(0, e);
	endtask
	task automatic wrap_up();
		if (fails == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		wrap_up();
	end
	initial begin
		rs();
		rdc(8'h8F, 8'h00);
		rdc(8'hAF, 8'h0F);
		rdc(8'hB6, 8'h03);
		rdc(8'hB7, 8'h00);
		wr(8'h8F, 8'hFF);
		rdc(8'h8F, 8'h03);
		wr(8'hAF, 8'hF7);
		rdc(8'hAF, 8'h07);
		wr(8'hB6, 8'hF3);
		rdc(8'hB6, 8'h10);
		fch(8'h13, 2);
		fch(8'h03, 1);
		wr(8'h8F, 8'h00);
		mv(1, 16'h0100);
		dlt(3, 1);
		dlt(1, 0);
		chk(ra, 16'h0100);
		chk({8'h00, rdd}, 16'h003C);
		wr(8'hB7, 8'hA5);
		rdc(8'hB7, 8'h01);
		wr(8'hB7, 8'hF1);
		rdc(8'hB7, 8'h02);
		wr(8'h8F, 8'h03);
		mv(1, 16'h0345);
		dlt(2, 16);
		dlt(5, 16);
		chk(ea, 16'h0200);
		chk({8'h00, ed}, 16'h00FF);
		rdc(8'hB7, 8'h00);
		unl(8'h01);
		mv(1, 16'h0200);
		dlt(1, 4);
		dlt(3, 0);
		dlt(5, 4);
		chk(pa, 16'h0200);
		chk({8'h00, pd}, 16'h003C);
		rdc(8'hB7, 8'h00);
		unl(8'h01);
		mv(1, 16'h7E10);
		dlt(4, 1);
		dlt(1, 0);
		mv(0, 16'h7FFF);
		dlt(4, 1);
		for (int k = 0; k < 2; k++) begin
			rs();
			mon = k[0];
			ren = !k[0];
			unl(8'h01);
			mv(1, 16'h0010);
			dlt(4, 1);
			dlt(1, 0);
		end
		mon = 1;
		ren = 1;
		rs();
		wr(8'h8F, 8'h01);
		mv(1, 16'h0020);
		dlt(1, 0);
		rdc(8'hB7, 8'h03);
		unl(8'h01);
		rdc(8'hB7, 8'h03);
		rs();
		wr(8'hB7, 8'h12);
		rdc(8'hB7, 8'h03);
		rs();
		unl(8'h00);
		wr(8'hB7, 8'hA5);
		rdc(8'hB7, 8'h03);
		wrap_up();
	end
endmodule
